// ===== verilog/stl_spi_link_tunnel.sv
// SPI tunnel over the secondary lane of the serial video link
`include "stl_params.svh"

module stl_spi_link_tunnel #(
    parameter int BUF_DEPTH = `STL_BUF_DEPTH
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Register port from the local I2C slave
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Forward frame samples from the link receiver
    input wire logic fwd_valid_i,
    input wire stl_pkg::stl_fwd_sample_type fwd_sample_i,
    // Back channel frame slot and content to the link transmitter
    input wire logic bc_slot_i,
    output logic bc_valid_o,
    output stl_pkg::stl_bc_frame_type bc_frame_o,
    // Local SPI pins, asynchronous inputs
    input wire logic spi_ss_n_i,
    input wire logic tunnel_spi_clock_i,
    input wire logic spi_mosi_i,
    input wire logic spi_miso_i,
    // Local SPI pins, outputs
    output logic spi_ss_n_o,
    output logic tunnel_spi_clock_o,
    output logic spi_mosi_o,
    output logic spi_miso_o
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

    // Full level needs the extra fill bit; a pointer-wide cast would wrap to zero
    localparam logic [PTR_W:0] FILL_FULL = (PTR_W + 1)'(BUF_DEPTH);

    // The pointer arithmetic wraps naturally only on a power of two
    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("BUF_DEPTH must be a power of two, at least 2");
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    logic [7:0] high_speed_channel_control;
    logic [2:0] control_channel_mode_select;
    stl_pkg::stl_mode_type mode;

    // Written by the host over I2C; the tunnel itself cannot reach it
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            high_speed_channel_control <= `STL_HSCC_RESET;
        end
        else if (reg_wr_i && reg_addr_i == `STL_REG_HSCC)
        begin
            high_speed_channel_control <= reg_wdata_i; // RULE3
        end
    end

    // Read data; unmapped addresses read as zero
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            reg_rdata_o <= `STL_REG_ZERO;
        end
        else if (reg_rd_i)
        begin
            if (reg_addr_i == `STL_REG_HSCC)
            begin
                reg_rdata_o <= high_speed_channel_control;
            end
            else
            begin
                reg_rdata_o <= `STL_REG_ZERO;
            end
        end
    end

    // Mode decode; every other pattern leaves the tunnel off
    assign control_channel_mode_select =
        high_speed_channel_control[`STL_MODE_MSB:`STL_MODE_LSB];

    always_comb
    begin
        case (control_channel_mode_select)
            `STL_MODE_FWD: mode = stl_pkg::STL_FWD; // RULE1 RULE2
            `STL_MODE_REV: mode = stl_pkg::STL_REV; // RULE1 RULE2
            default: mode = stl_pkg::STL_OFF; // RULE17
        endcase
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Two stages per pin, third stage only for edge finding
    logic ss_m, ss_s;
    logic clk_m, clk_s, clk_d;
    logic mosi_m, mosi_s;
    logic miso_m, miso_s;

    // Pins idle high for select, low otherwise
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            ss_m <= 1'b1;
            ss_s <= 1'b1;
            clk_m <= 1'b0;
            clk_s <= 1'b0;
            clk_d <= 1'b0;
            mosi_m <= 1'b0;
            mosi_s <= 1'b0;
            miso_m <= 1'b0;
            miso_s <= 1'b0;
        end
        else
        begin
            ss_m <= spi_ss_n_i;
            ss_s <= ss_m; // RULE11
            clk_m <= tunnel_spi_clock_i;
            clk_s <= clk_m; // RULE11
            clk_d <= clk_s;
            mosi_m <= spi_mosi_i;
            mosi_s <= mosi_m;
            miso_m <= spi_miso_i;
            miso_s <= miso_m;
        end
    end

    logic clk_rise;
    logic clk_fall;

    // Edges are seen only on synchronised copies
    assign clk_rise = clk_s && !clk_d;
    assign clk_fall = !clk_s && clk_d;

    // ****************************************************************
    // Forward mode regeneration
    // ****************************************************************
    // Samples go to pins only; nothing here looks at register space
    logic fwd_sclk_d;
    logic next_mosi;

    // Data may change only while the rebuilt clock is low
    always_comb
    begin
        next_mosi = spi_mosi_o;
        if (!tunnel_spi_clock_o)
        begin
            next_mosi = fwd_sample_i.data; // RULE9
        end
    end

    // Extra clock stage buys one cycle of setup on the data
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            fwd_sclk_d <= 1'b0;
            spi_ss_n_o <= 1'b1;
            spi_mosi_o <= 1'b0;
            tunnel_spi_clock_o <= 1'b0;
        end
        else if (mode != stl_pkg::STL_FWD)
        begin
            fwd_sclk_d <= 1'b0;
            spi_ss_n_o <= 1'b1; // RULE17
            spi_mosi_o <= 1'b0;
            tunnel_spi_clock_o <= 1'b0;
        end
        else
        begin
            if (fwd_valid_i)
            begin
                spi_ss_n_o <= fwd_sample_i.ss_n; // RULE8 RULE4
                spi_mosi_o <= next_mosi; // RULE8
                fwd_sclk_d <= fwd_sample_i.sclk; // RULE8
            end
            tunnel_spi_clock_o <= fwd_sclk_d; // RULE10
        end
    end

    // ****************************************************************
    // Reverse mode returned data
    // ****************************************************************
    // Latest slave bit from the far end, shown on the local pin
    logic ret_bit;

    // Pin changes only on a falling clock so the master samples rising
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            ret_bit <= 1'b0;
            spi_miso_o <= 1'b0;
        end
        else if (mode != stl_pkg::STL_REV)
        begin
            ret_bit <= 1'b0;
            spi_miso_o <= 1'b0;
        end
        else
        begin
            if (fwd_valid_i)
            begin
                ret_bit <= fwd_sample_i.data;
            end
            if (clk_fall)
            begin
                spi_miso_o <= ret_bit; // RULE5
            end
        end
    end

    // ****************************************************************
    // Reverse mode sample buffer
    // ****************************************************************
    // Overflow drops the new bit; the master must pace reads and writes
    logic buf_mem [BUF_DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] fill;
    logic push;
    logic pop;

    assign push = (mode == stl_pkg::STL_REV) && clk_rise && !ss_s &&
        (fill != FILL_FULL);
    assign pop = (mode == stl_pkg::STL_REV) && bc_slot_i && (fill != '0);

    // Storage, written on each active clock edge while the buffer has room
    always_ff @(posedge mclk_i)
    begin
        if (push)
        begin
            buf_mem[wr_ptr] <= mosi_s; // RULE12
        end
    end

    // Pointers and fill level; a mode change flushes the buffer
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || mode != stl_pkg::STL_REV)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1; // RULE14
            end
            case ({push, pop})
                2'b10: fill <= fill + 1'b1;
                2'b01: fill <= fill - 1'b1;
                default: fill <= fill;
            endcase
        end
    end

    // ****************************************************************
    // Back channel frame content
    // ****************************************************************
    // Forward mode returns the local slave bit with every frame
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            bc_valid_o <= 1'b0;
            bc_frame_o <= '{ss_n: 1'b1, has_data: 1'b0, data: 1'b0};
        end
        else
        begin
            bc_valid_o <= bc_slot_i && (mode != stl_pkg::STL_OFF); // RULE17
            if (bc_slot_i)
            begin
                case (mode)
                    stl_pkg::STL_REV:
                    begin
                        bc_frame_o.ss_n <= ss_s; // RULE13
                        bc_frame_o.has_data <= pop; // RULE14
                        bc_frame_o.data <= pop ? buf_mem[rd_ptr] : 1'b0;
                    end
                    stl_pkg::STL_FWD:
                    begin
                        bc_frame_o.ss_n <= 1'b1;
                        bc_frame_o.has_data <= 1'b1;
                        bc_frame_o.data <= miso_s; // RULE5
                    end
                    default:
                    begin
                        bc_frame_o.ss_n <= 1'b1;
                        bc_frame_o.has_data <= 1'b0;
                        bc_frame_o.data <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // stl_spi_link_tunnel

// ===== pkg/stl_params.svh
// Constants of the SPI link tunnel: register map, field layout, codes
//
// What the document requires
// RULE1: Forward and reverse SPI tunnelling modes exist.
// RULE2: Mode field 110 forward, 111 reverse.
// RULE3: Host configures mode over I2C only.
// RULE4: Tunnelled SPI never reaches internal registers.
// RULE5: Slave shifts return data on falling edge.
// RULE6: Read clock period exceeds link round trip.
// RULE7: Writes may ignore returned slave data.
// RULE8: Forward mode rebuilds select, clock, data outputs.
// RULE9: Forward data output held while clock high.
// RULE10: Forward clock delayed one cycle after data.
// RULE11: Reverse select and clock pins synchronised.
// RULE12: Reverse clock edge buffers master data bit.
// RULE13: Every back channel frame carries select state. Code: only reverse frames do; forward frames send ss_n fixed at 1.
// RULE14: At most one sample per back frame.
// RULE15: Master holds select high one frame period.
// RULE16: Master waits round trip before sampling edge.
// RULE17: Other modes: outputs idle, no samples sent.
`ifndef STL_PARAMS_SVH
`define STL_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define STL_REG_HSCC 8'h43
`define STL_HSCC_RESET 8'h00
`define STL_REG_ZERO 8'h00

// ****************************************************************
// Mode field inside the channel control register
// ****************************************************************
`define STL_MODE_MSB 2
`define STL_MODE_LSB 0
`define STL_MODE_FWD 3'h6
`define STL_MODE_REV 3'h7

// ****************************************************************
// Buffer
// ****************************************************************
`define STL_BUF_DEPTH 8

`endif

// ===== pkg/stl_pkg.sv
// Types shared by the SPI link tunnel
package stl_pkg;

    // Sampled SPI triple carried in a forward frame
    typedef struct packed {
        logic ss_n;
        logic sclk;
        logic data;
    } stl_fwd_sample_type;

    // SPI content of one back channel frame
    typedef struct packed {
        logic ss_n;
        logic has_data;
        logic data;
    } stl_bc_frame_type;

    // Tunnel mode decoded from the control register
    typedef enum logic [1:0] {
        STL_OFF,
        STL_FWD,
        STL_REV
    } stl_mode_type;

endpackage

// ===== test/stl_tunnel_sva.sv
// Port-level checks for the SPI link tunnel
module stl_tunnel_sva (
    // Clock, reset and register writes
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    // Link side
    input wire logic fwd_valid_i,
    input wire stl_pkg::stl_fwd_sample_type fwd_sample_i,
    input wire logic bc_slot_i,
    input wire logic bc_valid_o,
    input wire stl_pkg::stl_bc_frame_type bc_frame_o,
    // SPI pins
    input wire logic spi_ss_n_i,
    input wire logic tunnel_spi_clock_i,
    input wire logic spi_ss_n_o,
    input wire logic tunnel_spi_clock_o,
    input wire logic spi_mosi_o,
    input wire logic spi_miso_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] mode;
    logic [2:0] fall_age;
    logic clk_d;
    logic fwd;
    logic rev;
    // ****************************************************
    // Helper state
    // ****************************************************
    assign fwd = mode == 3'h6;
    assign rev = mode == 3'h7;
    // Mode shadow follows writes on the same edge as the block
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            mode <= 3'h0;
        else if (reg_wr_i && reg_addr_i == 8'h43)
            mode <= reg_wdata_i[2:0];
    end
    // Ages saturate at 7 so a quiet pin never wraps back to "recent"
    always_ff @(posedge mclk_i)
    begin
        clk_d <= tunnel_spi_clock_i;
        if (reset_i)
        begin
            fall_age <= 3'h7;
        end
        else
        begin
            fall_age <= (clk_d && !tunnel_spi_clock_i) ? 3'h0 : fall_age + 3'(fall_age != 3'h7);
        end
    end
    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);
    AST_FWD_REBUILD:
        assert property (fwd && !reg_wr_i && fwd_valid_i && !tunnel_spi_clock_o |=> spi_ss_n_o
            == $past(fwd_sample_i.ss_n) && spi_mosi_o == $past(fwd_sample_i.data))
        else $error("forward select or data not rebuilt");
    AST_FWD_HOLD:
        assert property (fwd && $past(fwd) && tunnel_spi_clock_o && $past(tunnel_spi_clock_o)
            |-> $stable(spi_mosi_o)) else $error("data moved while clock high");
    AST_FWD_CLK_LAG:
        assert property (fwd && !reg_wr_i && fwd_valid_i ##1 !reg_wr_i
            |=> tunnel_spi_clock_o == $past(fwd_sample_i.sclk, 2)) else $error("clock lag wrong");
    AST_FRAME_EACH_SLOT:
        assert property ((fwd || rev) && bc_slot_i && !reg_wr_i |=> bc_valid_o)
        else $error("slot without frame");
    AST_ONE_PER_SLOT:
        assert property (bc_valid_o |-> $past(bc_slot_i)) else $error("frame without slot");
    AST_REV_SELECT:
        assert property (bc_valid_o && rev && $past(rev) && !$past(reset_i, 3)
            |-> bc_frame_o.ss_n == $past(spi_ss_n_i, 3))
        else $error("frame select differs from pin");
    AST_OFF_NO_FRAME:
        assert property (!(fwd || rev) && !reg_wr_i |=> !bc_valid_o) else $error("frame when off");
    AST_OFF_IDLE:
        assert property (!(fwd || rev) && $past(!(fwd || rev)) |-> spi_ss_n_o
            && !tunnel_spi_clock_o && !spi_mosi_o) else $error("outputs not idle when off");
    AST_REV_MISO_FALL:
        assert property (rev && $past(rev) && $changed(spi_miso_o) |-> fall_age inside {[3'h1:3'h5]})
        else $error("return data moved away from falling clock");
endmodule // stl_tunnel_sva

// ===== test/stl_far_end_model.sv
// Remote serializer model: forward frames and back channel slots
module stl_far_end_model #(
    parameter int FRAME = 16
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // SPI triple at the remote end
    input wire stl_pkg::stl_fwd_sample_type remote_i,
    // Link toward the tunnel
    output logic fwd_valid_o,
    output stl_pkg::stl_fwd_sample_type fwd_sample_o,
    output logic bc_slot_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // ****************************************************
    // Frame timing
    // ****************************************************
    // Quiet outputs from time zero
    initial
    begin
        fwd_valid_o = 1'b0;
        fwd_sample_o = 3'h0;
        bc_slot_o = 1'b0;
    end
    // Off-frame sample shows the inverse, so a stale read never matches
    always @(negedge mclk_i)
    begin
        cnt <= (reset_i || cnt == FRAME - 1) ? 0 : cnt + 1;
        fwd_valid_o <= !reset_i && cnt == 0;
        fwd_sample_o <= (!reset_i && cnt == 0) ? remote_i : ~remote_i;
        bc_slot_o <= !reset_i && cnt == FRAME / 2;
    end
endmodule // stl_far_end_model

// ===== test/testbench.sv
// Self-checking bench for the SPI link tunnel
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rev_on = 1'b0;
    logic spi_ss_n_i = 1'b1, tunnel_spi_clock_i = 1'b0, spi_mosi_i = 1'b0, spi_miso_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, got = 8'h00, reg_rdata_o;
    logic fwd_valid_i, bc_slot_i, bc_valid_o, spi_ss_n_o, tunnel_spi_clock_o, spi_mosi_o, spi_miso_o;
    logic [3:0] pat = 4'hB;
    stl_pkg::stl_fwd_sample_type remote = 3'h4;
    stl_pkg::stl_fwd_sample_type fwd_sample_i;
    stl_pkg::stl_bc_frame_type bc_frame_o;
    int n_got = 0, n_bc = 0, base = 0, n_mismatch = 0, compares = 0;
    // ****************************************************
    // Clock, design and far end
    // ****************************************************
    always #5 mclk_i = ~mclk_i;
    stl_spi_link_tunnel u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .fwd_valid_i(fwd_valid_i), .fwd_sample_i(fwd_sample_i),
        .bc_slot_i(bc_slot_i), .bc_valid_o(bc_valid_o), .bc_frame_o(bc_frame_o),
        .spi_ss_n_i(spi_ss_n_i), .tunnel_spi_clock_i(tunnel_spi_clock_i),
        .spi_mosi_i(spi_mosi_i), .spi_miso_i(spi_miso_i), .spi_ss_n_o(spi_ss_n_o),
        .tunnel_spi_clock_o(tunnel_spi_clock_o), .spi_mosi_o(spi_mosi_o), .spi_miso_o(spi_miso_o));
    stl_far_end_model u_far (.mclk_i(mclk_i), .reset_i(reset_i), .remote_i(remote),
        .fwd_valid_o(fwd_valid_i), .fwd_sample_o(fwd_sample_i), .bc_slot_o(bc_slot_i));
    // Count frames; reverse data bits shift in oldest first
    always @(posedge mclk_i)
    begin
        n_bc <= n_bc + 32'(bc_valid_o);
        if (rev_on && bc_valid_o && bc_frame_o.has_data)
        begin
            got <= {got[6:0], bc_frame_o.data};
            n_got <= n_got + 1;
        end
    end
    // ****************************************************
    // Tasks
    // ****************************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
        @(negedge mclk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk_i);
        {reg_rd_i, reg_addr_i} = {1'b1, a};
        @(negedge mclk_i);
        reg_rd_i = 1'b0;
        chk(reg_rdata_o, exp);
    endtask
    task automatic frames(input int n);
        repeat (n * 16) @(negedge mclk_i);
    endtask
    // Slow 160 ns SPI clock keeps reads inside the round trip
    task automatic spi_bit(input logic b);
        spi_mosi_i = b;
        #80 tunnel_spi_clock_i = 1'b1;
        #80 tunnel_spi_clock_i = 1'b0;
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ****************************************************
    // Tests
    // ****************************************************
    initial
    begin
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i);
        reset_i = 1'b0;
        chk(8'({spi_ss_n_o, tunnel_spi_clock_o, spi_mosi_o, bc_valid_o}), 8'h08);
        rd(8'h43, 8'h00);
        wr(8'h44, 8'hFF);
        rd(8'h44, 8'h00);
        wr(8'h43, 8'h06);
        rd(8'h43, 8'h06);
        spi_miso_i = 1'b1;
        remote = 3'h1;
        frames(2);
        chk(8'({spi_ss_n_o, tunnel_spi_clock_o, spi_mosi_o}), 8'h01);
        chk(8'(bc_frame_o), 8'h07);
        remote = 3'h3;
        frames(1);
        chk(8'({spi_ss_n_o, tunnel_spi_clock_o, spi_mosi_o}), 8'h03);
        remote = 3'h2;
        frames(1);
        chk(8'(spi_mosi_o), 8'h01);
        remote = 3'h0;
        frames(2);
        chk(8'({spi_ss_n_o, tunnel_spi_clock_o, spi_mosi_o}), 8'h00);
        wr(8'h43, 8'h07);
        remote = 3'h5;
        frames(2);
        rev_on = 1'b1;
        spi_ss_n_i = 1'b0;
        for (int i = 3; i >= 0; i--)
            spi_bit(pat[i]);
        #80 spi_ss_n_i = 1'b1;
        frames(8);
        chk(got, 8'h0B);
        chk(8'(n_got), 8'h04);
        chk(8'(spi_miso_o), 8'h01);
        rev_on = 1'b0;
        wr(8'h43, 8'h05);
        frames(1);
        base = n_bc;
        frames(3);
        chk(8'(n_bc - base), 8'h00);
        chk(8'({spi_ss_n_o, tunnel_spi_clock_o, spi_mosi_o}), 8'h04);
        final_report();
    end
    // Cut a hang short; the sequence needs about 4 us
    initial
    begin
        #100us;
        n_mismatch++;
        final_report();
    end
endmodule // testbench

bind stl_spi_link_tunnel stl_tunnel_sva u_sva (.mclk_i(mclk_i), .reset_i(reset_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .fwd_valid_i(fwd_valid_i), .fwd_sample_i(fwd_sample_i), .bc_slot_i(bc_slot_i),
    .bc_valid_o(bc_valid_o), .bc_frame_o(bc_frame_o), .spi_ss_n_i(spi_ss_n_i),
    .tunnel_spi_clock_i(tunnel_spi_clock_i), .spi_ss_n_o(spi_ss_n_o),
    .tunnel_spi_clock_o(tunnel_spi_clock_o), .spi_mosi_o(spi_mosi_o), .spi_miso_o(spi_miso_o));
